// file: verification/analog_model.sv
/*
 Comparator and analog input model for the converter bench.
 Assumes channel n carries base code plus eight times n.
*/
`timescale 1ns/1ns
module analog_model (
   // Level and DAC
   input wire logic [9:0] i_vin,
   input wire logic [9:0] i_dac_code,
   input wire logic [4:0] i_channel,
   // Comparator
   output logic o_comp_high
);
   ////////////////////////////////////////
   // High when input at or above DAC level
   assign o_comp_high = (i_vin + {2'h0, i_channel, 3'h0}) >= i_dac_code;
endmodule : analog_model

// file: verification/sar_adc_sequencer_powerfail_bench.sv
/*
 Bench for the converter control block: APB tasks and directed tests.
 Assumes the comparator model and a 20 MHz clock.
*/
`timescale 1ns/1ns
module sar_adc_sequencer_powerfail_bench;
   import adc_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, comp;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, sh, irq, act, e;
   logic [9:0] dac, vin = 0, v;
   logic [4:0] ch;
   logic [2:0] trg = 0;
   logic [7:0] pfm [5] = '{8'h00, 8'h80, 8'h80, 8'hc0, 8'hc0};
   logic [7:0] thr [5] = '{8'hff, 8'ha9, 8'haa, 8'haa, 8'ha9};
   logic hit [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
   int n_fail = 0, n_checks = 0, n, k, k2;
   sar_adc_sequencer_powerfail uut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_comp_high(comp),
      .o_dac_code(dac), .o_sample_hold(sh), .o_channel(ch),
      .i_external_trigger_pin(trg[0]), .i_timer_match_event_0(trg[1]),
      .i_timer_match_event_1(trg[2]), .o_conversion_end_irq(irq),
      .o_conversion_active(act));
   analog_model far_side (.i_vin(vin), .i_dac_code(dac), .i_channel(ch), .o_comp_high(comp));
   initial begin
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////
   task finish_test;
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask : apb
   task wait_irq;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq !== 1'b1 && n < 150);
   endtask : wait_irq
   ////////////////////////////////////////
   initial begin
      #1000000;
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      apb(0, PFM_OFS, 0); chk(r, 0);
      apb(0, PFT_OFS, 0); chk(r, 0);
      apb(0, HWT_OFS, 0); chk(r, 0);
      apb(0, 8'h30, 0); chk(e, 1);
      apb(1, PFM_OFS, 32'hff);
      apb(0, PFM_OFS, 0); chk(r, 32'hc0);
      apb(1, PFM_OFS, 0);
      // One-shot select on channel 5
      vin <= 10'h2a5;
      v = 10'h2cd;
      apb(1, CHS_OFS, 5);
      apb(1, CTL0_OFS, 32'ha0);
      k = 0;
      while (sh !== 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      chk(ch, 5);
      k2 = 0;
      while (sh === 1'b1 && k2 < 40) begin
         @(posedge clk);
         k2++;
      end
      chk(k2, SAMPLE_CYC);
      chk(dac, 10'h200);
      wait_irq(); chk(n < 150, 1);
      apb(0, RES_BASE + 8'd20, 0); chk(r, {8'h00, v[9:2], v, 6'h00});
      chk(act, 0);
      wait_irq(); chk(n, 150);
      // Power-fail gating on channel 0
      apb(1, CHS_OFS, 0);
      for (int i = 0; i < 5; i++) begin
         apb(1, PFM_OFS, pfm[i]);
         apb(1, PFT_OFS, thr[i]);
         apb(1, CTL0_OFS, 32'ha0);
         wait_irq(); chk(n < 150, hit[i]);
      end
      apb(1, PFM_OFS, 0);
      // Config write mid-conversion restarts
      apb(1, CTL0_OFS, 32'ha0);
      repeat (30) @(posedge clk);
      apb(1, PFT_OFS, 0);
      wait_irq(); chk(n >= 55 && n < 150, 1);
      // Continuous select
      apb(1, CTL0_OFS, 32'h80);
      wait_irq(); chk(act, 1);
      apb(0, CTL0_OFS, 0); chk(r, 32'h81);
      wait_irq(); chk(n < 150, 1);
      apb(1, CTL0_OFS, 0);
      repeat (2) @(posedge clk);
      chk(act, 0);
      // Hardware trigger sources
      for (int s = 0; s < 4; s++) begin
         apb(1, HWT_OFS, s);
         apb(1, CTL0_OFS, 32'hc0);
         wait_irq(); chk(n, 150);
         chk(act, 0);
         trg <= (s == 3) ? 3'h7 : 3'(1 << s);
         repeat (4) @(posedge clk);
         trg <= 0;
         wait_irq(); chk(n < 150, s != 3);
         apb(1, CTL0_OFS, 0);
      end
      // One-shot scan of channels 0 to 2, gate on channel 0 byte
      apb(1, CHS_OFS, 2);
      apb(1, PFM_OFS, 32'hc0);
      apb(1, PFT_OFS, 32'hab);
      apb(1, CTL0_OFS, 32'hb0);
      wait_irq(); chk(n, 150);
      wait_irq(); chk(n < 150, 1);
      v = 10'h2ad;
      apb(0, RES_BASE + 8'd4, 0); chk(r, {8'h00, v[9:2], v, 6'h00});
      v = 10'h2b5;
      apb(0, RES_BASE + 8'd8, 0); chk(r, {8'h00, v[9:2], v, 6'h00});
      chk(act, 0);
      finish_test();
   end
endmodule : sar_adc_sequencer_powerfail_bench

// file: verilog/adc_pkg.sv
/*
 Shared constants and types for the successive-approximation converter control block.
 Assumes a 20 MHz reference clock and a 32-bit APB register bus with byte addresses.
*/
package adc_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_NS = 50;
   localparam int SAMPLE_NS = 1000;
   localparam int SETTLE_NS = 200;
   localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_CYC = SAMPLE_CYC + 10 * SETTLE_CYC;
   localparam logic [7:0] SAMPLE_LOAD = 8'(SAMPLE_CYC - 1);
   localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);
   ////////////////////////////////////////////////////////////////////////
   // Approximation
   localparam logic [3:0] MSB_IDX = 4'h9;
   localparam logic [9:0] MSB_TRIAL = 10'h200;
   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] CTL0_OFS = 8'h00;
   localparam logic [7:0] TIM_OFS = 8'h04;
   localparam logic [7:0] HWT_OFS = 8'h08;
   localparam logic [7:0] CHS_OFS = 8'h0c;
   localparam logic [7:0] PFM_OFS = 8'h10;
   localparam logic [7:0] PFT_OFS = 8'h14;
   localparam logic [7:0] RES_BASE = 8'h40;
   ////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int CTL_EN_BIT = 7;
   localparam int CTL_HW_BIT = 6;
   localparam int CTL_MODE_HI = 5;
   localparam int CTL_MODE_LO = 4;
   localparam int CTL_ACT_BIT = 0;
   localparam int PF_EN_BIT = 7;
   localparam int PF_DIR_BIT = 6;
   localparam logic [7:0] REG8_RST = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // Encodings
   localparam logic [1:0] HW_EXT = 2'h0;
   localparam logic [1:0] HW_TMR0 = 2'h1;
   localparam logic [1:0] HW_TMR1 = 2'h2;
   typedef struct packed {
      logic en;
      logic hw;
      logic [1:0] mode;
   } ctl_t;
   typedef enum logic [1:0] {E_IDLE = 2'b00, E_SAMPLE = 2'b01, E_BIT = 2'b10} eng_state_t;
   typedef enum logic [1:0] {R_STOP = 2'b00, R_WAIT = 2'b01, R_CONV = 2'b10, R_PEND = 2'b11} run_t;
endpackage : adc_pkg

// file: verilog/bit_sync.sv
/*
 Two-flop synchroniser for a single level from outside the clock domain.
 Assumes the input is a slow level; pulses shorter than one clock may be lost.
*/
`timescale 1ns/1ns
module bit_sync (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Level
   input wire logic i_level,
   output logic o_level
);
   logic meta_reg;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= 1'b0;
         o_level <= 1'b0;
      end else begin
         meta_reg <= i_level;
         o_level <= meta_reg;
      end
   end
endmodule : bit_sync

// file: verilog/sar_adc_sequencer_powerfail.sv
/*
 Converter control: APB registers, trigger selection, channel sequencing,
 result storage and power-fail gated conversion-end interrupt.
 Assumes an external DAC and comparator (high when input >= DAC level) and
 trigger sources on the same clock except the external trigger pin.
*/
//Contract
// - Enable starts conversion at once in software mode, else waits for trigger.
// - Input is sampled for a fixed period, then held until conversion ends.
// - Approximation starts with bit 9 set, DAC at half reference.
// - Bit 9 kept when input at or above half reference, else cleared.
// - Bit 8 trial at three or one quarter; kept when input at or above.
// - Same trial step repeats down to bit 0, ten comparisons.
// - Final value goes to the channel result register, interrupt in the same cycle.
// - Software or hardware trigger class; two-bit field picks hardware source.
// - Software mode converts selected channel; result and interrupt together.
// - Software mode: continuous restarts until enable cleared, one-shot converts once; hardware mode waits for the next trigger.
// - Active flag set whenever a conversion begins.
// - Software mode: config register write mid-conversion aborts and restarts.
// - Power-fail control byte resets to zero, holds enable and direction.
// - Threshold byte resets to zero, compared with upper eight result bits.
// - Compare disabled: interrupt after every completed select conversion or full scan.
// - Compare enabled, direction 0: interrupt only when upper byte >= threshold.
// - Compare enabled, direction 1: interrupt only when upper byte < threshold.
// - Hardware field: 00 pin edge, 01 timer 0, 10 timer 1, 11 none.
`timescale 1ns/1ns
module sar_adc_sequencer_powerfail import adc_pkg::*; #(
   parameter int CH_N = 24
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Analog front end
   input wire logic i_comp_high,
   output logic [9:0] o_dac_code,
   output logic o_sample_hold,
   output logic [4:0] o_channel,
   // Triggers
   input wire logic i_external_trigger_pin,
   input wire logic i_timer_match_event_0,
   input wire logic i_timer_match_event_1,
   // Status
   output logic o_conversion_end_irq,
   output logic o_conversion_active
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ctl_t ctl_reg;
   logic [7:0] tim_reg;
   logic [1:0] hwt_reg;
   logic [4:0] chs_reg;
   logic [7:0] pfm_reg;
   logic [7:0] pft_reg;
   logic [9:0] res_mem [CH_N];
   run_t run_reg;
   logic [4:0] ch_reg;
   logic start_reg;
   logic abort_reg;
   logic ext_sync;
   logic comp_sync;
   logic ext_d_reg;
   logic tm0_d_reg;
   logic tm1_d_reg;
   logic hw_edge;
   logic wr_en;
   logic wr_ctl0;
   logic cfg_wr;
   logic hw_next;
   logic scan;
   logic last;
   logic [4:0] first_ch;
   logic [7:0] cmp_byte;
   logic eng_done;
   logic [9:0] eng_res;
   logic [7:0] rel_addr;
   logic [4:0] res_idx;
   logic res_hit;
   logic [31:0] rd_data;
   logic rd_ok;

   function automatic logic is_cfg(input logic [7:0] a);
      return a == CTL0_OFS || a == HWT_OFS ||
             a == CHS_OFS || a == PFM_OFS || a == PFT_OFS;
   endfunction : is_cfg

   function automatic logic pf_pass(input logic [7:0] b, input logic [7:0] pfm,
                                    input logic [7:0] thr);
      if (!pfm[PF_EN_BIT]) begin
         return 1'b1;
      end
      return pfm[PF_DIR_BIT] ? (b < thr) : (b >= thr);
   endfunction : pf_pass

   ////////////////////////////////////////////////////////////////////////
   // APB slave, one wait-free access phase
   assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
   assign wr_ctl0 = wr_en && i_paddr == CTL0_OFS;
   assign cfg_wr = wr_en && is_cfg(i_paddr);
   assign rel_addr = i_paddr - RES_BASE;
   assign res_idx = rel_addr[6:2];
   assign res_hit = i_paddr >= RES_BASE && !rel_addr[7] && rel_addr[1:0] == 2'b00 &&
                    res_idx < 5'(CH_N);

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      if (res_hit) begin
         rd_data = {8'h00, res_mem[res_idx][9:2], res_mem[res_idx], 6'h00};
      end else begin
         unique case (i_paddr)
            CTL0_OFS: begin
               rd_data[CTL_EN_BIT] = ctl_reg.en;
               rd_data[CTL_HW_BIT] = ctl_reg.hw;
               rd_data[CTL_MODE_HI] = ctl_reg.mode[1];
               rd_data[CTL_MODE_LO] = ctl_reg.mode[0];
               rd_data[CTL_ACT_BIT] = o_conversion_active;
            end
            TIM_OFS: rd_data[7:0] = tim_reg;
            HWT_OFS: rd_data[1:0] = hwt_reg;
            CHS_OFS: rd_data[4:0] = chs_reg;
            PFM_OFS: rd_data[7:0] = pfm_reg;
            PFT_OFS: rd_data[7:0] = pft_reg;
            default: rd_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin : apb_resp
      if (i_rst) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_prdata <= rd_data;
         o_pslverr <= i_psel && !i_penable && !rd_ok;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin : cfg_regs
      if (i_rst) begin
         ctl_reg <= '0;
         tim_reg <= REG8_RST;
         hwt_reg <= 2'h0;
         chs_reg <= 5'h00;
         pfm_reg <= REG8_RST;
         pft_reg <= REG8_RST;
      end else if (wr_en) begin
         unique case (i_paddr)
            CTL0_OFS: begin
               ctl_reg.en <= i_pwdata[CTL_EN_BIT];
               ctl_reg.hw <= i_pwdata[CTL_HW_BIT];
               ctl_reg.mode <= {i_pwdata[CTL_MODE_HI], i_pwdata[CTL_MODE_LO]};
            end
            TIM_OFS: tim_reg <= i_pwdata[7:0];
            HWT_OFS: hwt_reg <= i_pwdata[1:0];
            CHS_OFS: chs_reg <= i_pwdata[4:0];
            PFM_OFS: begin
               pfm_reg <= 8'h00;
               pfm_reg[PF_EN_BIT] <= i_pwdata[PF_EN_BIT];
               pfm_reg[PF_DIR_BIT] <= i_pwdata[PF_DIR_BIT];
            end
            PFT_OFS: pft_reg <= i_pwdata[7:0];
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trigger sources
   bit_sync u_ext_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_level(i_external_trigger_pin),
      .o_level(ext_sync)
   );

   bit_sync u_comp_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_level(i_comp_high),
      .o_level(comp_sync)
   );

   always_ff @(posedge i_ref_clk or posedge i_rst) begin : trig_edges
      if (i_rst) begin
         ext_d_reg <= 1'b0;
         tm0_d_reg <= 1'b0;
         tm1_d_reg <= 1'b0;
      end else begin
         ext_d_reg <= ext_sync;
         tm0_d_reg <= i_timer_match_event_0;
         tm1_d_reg <= i_timer_match_event_1;
      end
   end

   always_comb begin
      unique case (hwt_reg)
         HW_EXT: hw_edge = ext_sync && !ext_d_reg;
         HW_TMR0: hw_edge = i_timer_match_event_0 && !tm0_d_reg;
         HW_TMR1: hw_edge = i_timer_match_event_1 && !tm1_d_reg;
         default: hw_edge = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   assign hw_next = wr_ctl0 ? i_pwdata[CTL_HW_BIT] : ctl_reg.hw;
   assign scan = ctl_reg.mode[0];
   assign first_ch = scan ? 5'h00 : chs_reg;
   assign last = !scan || ch_reg == chs_reg;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin : sequencer
      if (i_rst) begin
         run_reg <= R_STOP;
         ch_reg <= 5'h00;
         start_reg <= 1'b0;
         abort_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         abort_reg <= 1'b0;
         if (wr_ctl0 && !i_pwdata[CTL_EN_BIT]) begin
            run_reg <= R_STOP;
            abort_reg <= 1'b1;
         end else if ((wr_ctl0 && i_pwdata[CTL_EN_BIT]) || (cfg_wr && run_reg != R_STOP)) begin
            abort_reg <= 1'b1;
            run_reg <= hw_next ? R_WAIT : R_PEND;
         end else begin
            unique case (run_reg)
               R_STOP: begin
               end
               R_PEND: begin
                  ch_reg <= first_ch;
                  start_reg <= 1'b1;
                  run_reg <= R_CONV;
               end
               R_WAIT: begin
                  if (hw_edge) begin
                     ch_reg <= first_ch;
                     start_reg <= 1'b1;
                     run_reg <= R_CONV;
                  end
               end
               R_CONV: begin
                  if (ctl_reg.hw && hw_edge) begin
                     ch_reg <= first_ch;
                     start_reg <= 1'b1;
                  end else if (eng_done) begin
                     if (!last) begin
                        ch_reg <= ch_reg + 5'h01;
                        start_reg <= 1'b1;
                     end else if (!ctl_reg.hw && !ctl_reg.mode[1]) begin
                        ch_reg <= first_ch;
                        start_reg <= 1'b1;
                     end else begin
                        run_reg <= ctl_reg.hw ? R_WAIT : R_STOP;
                     end
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin : active_flag
      if (i_rst) begin
         o_conversion_active <= 1'b0;
      end else begin
         o_conversion_active <= run_reg == R_CONV || run_reg == R_PEND;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Approximation engine
   sar_engine u_engine (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_start(start_reg),
      .i_abort(abort_reg),
      .i_comp(comp_sync),
      .o_done(eng_done),
      .o_result(eng_res),
      .o_dac(o_dac_code),
      .o_sample(o_sample_hold)
   );

   assign o_channel = ch_reg;

   ////////////////////////////////////////////////////////////////////////
   // Results and interrupt
   assign cmp_byte = (scan && ch_reg != 5'h00) ? res_mem[0][9:2] : eng_res[9:2];

   always_ff @(posedge i_ref_clk or posedge i_rst) begin : results
      if (i_rst) begin
         for (int i = 0; i < CH_N; i++) begin
            res_mem[i] <= 10'h000;
         end
      end else if (eng_done && ch_reg < 5'(CH_N)) begin
         res_mem[ch_reg] <= eng_res;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin : irq
      if (i_rst) begin
         o_conversion_end_irq <= 1'b0;
      end else begin
         o_conversion_end_irq <= eng_done && last && pf_pass(cmp_byte, pfm_reg, pft_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   start_active_a: assert property (start_reg |-> ##1 o_conversion_active)
      else $error("active flag not set at start");
   irq_cause_a: assert property (o_conversion_end_irq |-> $past(eng_done))
      else $error("interrupt without completed conversion");
   irq_plain_a: assert property (
      eng_done && last && !pfm_reg[PF_EN_BIT] |=> o_conversion_end_irq)
      else $error("interrupt missing with compare off");
   irq_ge_a: assert property (
      eng_done && last && pfm_reg[PF_EN_BIT] && !pfm_reg[PF_DIR_BIT]
      |=> o_conversion_end_irq == ($past(cmp_byte) >= $past(pft_reg)))
      else $error("greater-equal gate wrong");
   irq_lt_a: assert property (
      eng_done && last && pfm_reg[PF_EN_BIT] && pfm_reg[PF_DIR_BIT]
      |=> o_conversion_end_irq == ($past(cmp_byte) < $past(pft_reg)))
      else $error("less-than gate wrong");
   sw_restart_a: assert property (
      run_reg == R_CONV && !ctl_reg.hw && cfg_wr && !wr_ctl0
      |=> run_reg == R_PEND && abort_reg ##1 start_reg)
      else $error("software mode write did not restart");
   hw_wait_a: assert property (
      wr_ctl0 && i_pwdata[CTL_EN_BIT] && i_pwdata[CTL_HW_BIT]
      |=> run_reg == R_WAIT ##1 !o_conversion_active)
      else $error("hardware mode did not wait");
   oneshot_stop_a: assert property (
      run_reg == R_CONV && eng_done && last && !ctl_reg.hw && ctl_reg.mode[1] && !cfg_wr
      && !hw_edge |=> run_reg == R_STOP ##1 !o_conversion_active)
      else $error("one-shot did not stop");
   no_source_a: assert property (
      run_reg == R_WAIT && hwt_reg == 2'h3 && !cfg_wr |=> run_reg == R_WAIT)
      else $error("prohibited source triggered");

   sw_start_c: cover property (run_reg == R_PEND ##1 start_reg);
   irq_c: cover property (o_conversion_end_irq && pfm_reg[PF_EN_BIT]);
   hw_restart_c: cover property (run_reg == R_CONV && ctl_reg.hw && hw_edge);
   scan_wrap_c: cover property (eng_done && scan && last && !ctl_reg.mode[1]);
endmodule : sar_adc_sequencer_powerfail

// file: verilog/sar_engine.sv
/*
 Sample, hold and ten-step bit approximation engine driving the reference DAC.
 Assumes the comparator result arrives synchronised, within SETTLE_CYC of a DAC change.
*/
`timescale 1ns/1ns
module sar_engine import adc_pkg::*; (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_start,
   input wire logic i_abort,
   input wire logic i_comp,
   // Results
   output logic o_done,
   output logic [9:0] o_result,
   output logic [9:0] o_dac,
   output logic o_sample
);
   eng_state_t state_reg;
   logic [7:0] cnt_reg;
   logic [3:0] idx_reg;
   logic [7:0] since_reg;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= E_IDLE;
         cnt_reg <= 8'h00;
         idx_reg <= 4'h0;
         o_dac <= 10'h000;
         o_done <= 1'b0;
         o_result <= 10'h000;
         o_sample <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_abort) begin
            state_reg <= E_IDLE;
            o_sample <= 1'b0;
         end else if (i_start) begin
            state_reg <= E_SAMPLE;
            cnt_reg <= SAMPLE_LOAD;
            o_dac <= 10'h000;
            o_sample <= 1'b1;
         end else begin
            unique case (state_reg)
               E_IDLE: begin
               end
               E_SAMPLE: begin
                  if (cnt_reg == 8'h00) begin
                     state_reg <= E_BIT;
                     o_sample <= 1'b0;
                     idx_reg <= MSB_IDX;
                     o_dac <= MSB_TRIAL;
                     cnt_reg <= SETTLE_LOAD;
                  end else begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end
               end
               E_BIT: begin
                  if (cnt_reg != 8'h00) begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end else if (idx_reg == 4'h0) begin
                     o_dac[0] <= i_comp;
                     o_result <= {o_dac[9:1], i_comp};
                     o_done <= 1'b1;
                     state_reg <= E_IDLE;
                  end else begin
                     o_dac[idx_reg] <= i_comp;
                     o_dac[idx_reg - 4'h1] <= 1'b1;
                     idx_reg <= idx_reg - 4'h1;
                     cnt_reg <= SETTLE_LOAD;
                  end
               end
               default: state_reg <= E_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         since_reg <= 8'h00;
      end else if (i_start) begin
         since_reg <= 8'h00;
      end else if (since_reg != 8'hff) begin
         since_reg <= since_reg + 8'h01;
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   conv_length_a: assert property (o_done |-> since_reg == 8'(CONV_CYC))
      else $error("conversion length wrong");
   msb_trial_a: assert property (
      state_reg == E_SAMPLE && cnt_reg == 8'h00 && !i_start && !i_abort
      |=> o_dac == MSB_TRIAL && !o_sample)
      else $error("first trial not half scale");
   bit_keep_a: assert property (
      state_reg == E_BIT && cnt_reg == 8'h00 && idx_reg != 4'h0 && !i_start && !i_abort
      |=> o_dac[$past(idx_reg)] == $past(i_comp) && o_dac[$past(idx_reg) - 4'h1])
      else $error("bit decision not kept");
   hold_phase_a: assert property (state_reg == E_BIT |-> !o_sample)
      else $error("sampling during approximation");
   conv_done_c: cover property (o_done);
endmodule : sar_engine
